// File: logic/rc_map.svh
// register indices, field positions, reset values and timing of the remote pulse receiver
// Behaviour
// - match time is sixteen times threshold per tick
// - run bit zero stops and clears counter
// - threshold and run control resets to zero
// - read-only count capture register, reset zero
// - read-only received bits buffer, reset zero
// - read-only status register, reset zero
// - status shows receive bit counter value
// - overflow flag reads one after overflow
// - decision bit compares counter top nibble, threshold
// - status shows filtered input level
// - each measurement captures, clears, keeps counting; interrupts except in receive-end mode
// - overflow at FF interrupts, flags, clears, stops
// - writing run one clears overflow flag
// - receive-end mode shifts bits, interrupts per eight
`ifndef RC_MAP_SVH
`define RC_MAP_SVH
// register indices; byte address is four times the index
`define RC_IDX_MODE 14'h0fd0
`define RC_IDX_CTRL 14'h0fd1
`define RC_IDX_CAPT 14'h0fd2
`define RC_IDX_DBUF 14'h0fd3
`define RC_IDX_STAT 14'h0fd4
`define RC_IDX_ISTAT 14'h0fd5
`define RC_IDX_IMASK 14'h0fd6
// receive_mode_control fields
`define RC_MODE_POL 0
`define RC_MODE_EDGE 2:1
`define RC_MODE_PW 4
`define RC_MODE_MEAS 4:3
`define RC_MODE_NF 7:5
// threshold_and_run_control fields
`define RC_CTRL_RUN 0
`define RC_CTRL_THR 7:4
// interrupt edge select encodings
`define RC_EDGE_ACT 2'b00
`define RC_EDGE_INACT 2'b01
`define RC_EDGE_BOTH 2'b10
`define RC_EDGE_RXEND 2'b11
// counter and bit counter
`define RC_CNT_HI 7:4
`define RC_CNT_MAX 8'hff
`define RC_BITS_FULL 4'h8
`define RC_BITS_FIRST 4'h1
// receive counter clock is aclk divided by 64
`define RC_PRESC_LAST 6'h3f
// noise filter: stable time is 7 shifted by a per-select exponent
`define RC_NF_MUL 15'h0007
// interrupt status bits
`define RC_IRQ_RX 0
`define RC_IRQ_OVF 1
// bus answers
`define RC_RESP_OK 2'b00
`define RC_RESP_ERR 2'b10
`define RC_RD_PAD 24'h00_0000
`endif

// File: logic/rc_noise_filter.sv
// noise filter on the remote input with edge pulses of the filtered level
`timescale 1ns/10ps
`include "rc_map.svh"
module rc_noise_filter #(
  parameter int unsigned scale_shift = 0 // shortens stable times in simulation
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic sig_in, // raw remote input
  input wire logic [2:0] sel, // noise filter select, zero passes through
  output logic lvl, // filtered level
  output logic rise, // one-cycle pulse on filtered rising edge
  output logic fall // one-cycle pulse on filtered falling edge
);
  import rc_pkg::*;
  filt_s q;
  filt_s n;
  logic [3:0] ex;
  logic [14:0] limit;

  // exponent per select; longer settings reject longer glitches
  always_comb begin
    case (sel)
      3'h1: ex = 4'h2;
      3'h2: ex = 4'h5;
      3'h3: ex = 4'h6;
      3'h4: ex = 4'h7;
      3'h5: ex = 4'h8;
      3'h6: ex = 4'ha;
      3'h7: ex = 4'hb;
      default: ex = 4'h0;
    endcase
    limit = (sel == 3'h0) ? 15'h0000 : ((`RC_NF_MUL << ex) >> scale_shift);
  end

  // level follows input only after it differs for limit plus one cycles
  always_comb begin
    n = q;
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (sig_in == q.lvl) begin
      n.cnt = 15'h0000;
    end else if (q.cnt >= limit) begin
      n.lvl = sig_in;
      n.cnt = 15'h0000;
      n.rise = sig_in;
      n.fall = ~sig_in;
    end else begin
      n.cnt = q.cnt + 15'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign lvl = q.lvl;
  assign rise = q.rise;
  assign fall = q.fall;
endmodule : rc_noise_filter

// File: logic/rc_pkg.sv
// state types of the remote pulse receiver
package rc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_OVF = 2'b10
  } run_state_e;

  typedef struct packed {
    logic lvl;
    logic [14:0] cnt;
    logic rise;
    logic fall;
  } filt_s;

  typedef struct packed {
    logic [5:0] div;
    logic tick;
  } tick_s;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    run_state_e st;
    logic [7:0] cnt;
    logic [7:0] capt;
    logic [7:0] dbuf;
    logic [3:0] bits;
    logic ovf;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [15:0] awaddr;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rc_s;
endpackage : rc_pkg

// File: logic/rc_receiver.sv
// remote signal pulse receiver with axi4-lite register access
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "rc_map.svh"
module rc_receiver #(
  parameter int unsigned noise_scale_shift = 0 // shortens filter times in simulation
) (
  input wire logic aclk, // system clock, 250 mhz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic rc_in, // remote control receiver output
  input wire logic [15:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [15:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic irq // level interrupt, high while unmasked event pending
);
  import rc_pkg::*;

  rc_s q;
  rc_s n;
  logic tick;
  logic f_lvl;
  logic f_rise;
  logic f_fall;
  logic act;
  logic inact;
  logic meas;
  logic rxend;
  logic decide;
  logic rx_set;
  logic ov_set;
  logic wr;
  logic wr_ok;
  logic [13:0] wr_idx;
  logic [1:0] clr;
  logic [13:0] rd_idx;
  logic rd_ok;
  logic [7:0] rd_val;

  // receive counter clock
  rc_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // noise canceller and edge pulses of the filtered input
  rc_noise_filter #(
    .scale_shift(noise_scale_shift)
  ) u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(rc_in),
    .sel(q.mode[`RC_MODE_NF]),
    .lvl(f_lvl),
    .rise(f_rise),
    .fall(f_fall)
  );

  // edge steering; polarity only swaps edges, selection is by fields
  always_comb begin
    act = q.mode[`RC_MODE_POL] ? f_fall : f_rise;
    inact = q.mode[`RC_MODE_POL] ? f_rise : f_fall;
    rxend = (q.mode[`RC_MODE_EDGE] == `RC_EDGE_RXEND);
    case (q.mode[`RC_MODE_EDGE])
      `RC_EDGE_ACT: meas = act;
      `RC_EDGE_INACT: meas = inact;
      `RC_EDGE_BOTH: meas = act | inact;
      default: meas = act;
    endcase
  end

  // top nibble against threshold equals count against sixteen times it;
  // held low in ST_IDLE, so the decision bit reads zero out of reset and after run is written zero
  assign decide = (q.st != ST_IDLE) && (q.cnt[`RC_CNT_HI] >= q.ctrl[`RC_CTRL_THR]);

  // write decode; strobe lane 0 carries the whole 8-bit register
  assign wr = q.aw_have & q.w_have & ~q.bvalid;
  assign wr_idx = q.awaddr[15:2];
  assign wr_ok = (q.awaddr[1:0] == 2'b00) && (wr_idx >= `RC_IDX_MODE) && (wr_idx <= `RC_IDX_IMASK);

  // read decode straight from the address channel
  assign rd_idx = araddr[15:2];
  always_comb begin
    rd_ok = (araddr[1:0] == 2'b00);
    case (rd_idx)
      `RC_IDX_MODE: rd_val = q.mode;
      `RC_IDX_CTRL: rd_val = q.ctrl;
      `RC_IDX_CAPT: rd_val = q.capt;
      `RC_IDX_DBUF: rd_val = q.dbuf;
      `RC_IDX_STAT: rd_val = {q.bits, 1'b0, q.ovf, decide, f_lvl};
      `RC_IDX_ISTAT: rd_val = {6'h00, q.istat};
      `RC_IDX_IMASK: rd_val = {6'h00, q.imask};
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // next-state of the whole block
  always_comb begin
    n = q;
    rx_set = 1'b0;
    ov_set = 1'b0;
    clr = 2'b00;

    // measurement counter; edges take priority over the tick
    if (q.st == ST_RUN) begin
      if (meas) begin
        n.capt = q.cnt;
        n.cnt = 8'h00;
        if (rxend) begin
          n.dbuf = {q.dbuf[6:0], decide};
          // a new byte starts at one: this edge already shifts its first bit
          n.bits = (q.bits == `RC_BITS_FULL) ? `RC_BITS_FIRST : q.bits + 4'h1;
          rx_set = (n.bits == `RC_BITS_FULL);
        end else begin
          rx_set = 1'b1;
        end
      end else if (inact & q.mode[`RC_MODE_PW]) begin
        // pulse width mode restarts timing at the opposite edge
        n.cnt = 8'h00;
      end else if (tick) begin
        if (q.cnt == `RC_CNT_MAX) begin
          n.cnt = 8'h00;
          n.st = ST_OVF;
          n.ovf = 1'b1;
          ov_set = 1'b1;
          rx_set = 1'b1;
        end else begin
          n.cnt = q.cnt + 8'h01;
        end
      end
    end

    // address and data channels latch independently
    if (awvalid & q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid & q.wready) begin
      n.w_have = 1'b1;
      n.wdata = wdata[7:0];
      n.wlane = wstrb[0];
    end

    // register write once both halves are held
    if (wr) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_ok ? `RC_RESP_OK : `RC_RESP_ERR;
      if (wr_ok & q.wlane) begin
        case (wr_idx)
          `RC_IDX_MODE: n.mode = q.wdata;
          `RC_IDX_CTRL: begin
            n.ctrl = q.wdata;
            if (!q.wdata[`RC_CTRL_RUN]) begin
              n.st = ST_IDLE;
              n.cnt = 8'h00;
            end else begin
              // overflow seen in this same cycle still wins
              n.ovf = ov_set;
              if (q.st != ST_RUN) begin
                n.st = ST_RUN;
                n.cnt = 8'h00;
              end
            end
          end
          `RC_IDX_ISTAT: clr = q.wdata[1:0];
          `RC_IDX_IMASK: n.imask = q.wdata[1:0];
          default: n.mode = q.mode;
        endcase
      end
    end
    if (q.bvalid & bready) begin
      n.bvalid = 1'b0;
    end

    // read answer one cycle after the address is taken
    if (arvalid & q.arready) begin
      n.rvalid = 1'b1;
      n.rdata = {`RC_RD_PAD, rd_val};
      n.rresp = rd_ok ? `RC_RESP_OK : `RC_RESP_ERR;
    end
    if (q.rvalid & rready) begin
      n.rvalid = 1'b0;
    end

    // readies are registered so no channel sees a combinational path
    n.awready = ~n.aw_have;
    n.wready = ~n.w_have;
    n.arready = ~n.rvalid;

    // sticky events, write one clears, a new event beats the clear
    n.istat[`RC_IRQ_RX] = (q.istat[`RC_IRQ_RX] & ~clr[`RC_IRQ_RX]) | rx_set;
    n.istat[`RC_IRQ_OVF] = (q.istat[`RC_IRQ_OVF] & ~clr[`RC_IRQ_OVF]) | ov_set;
    n.irq = |(n.istat & n.imask);
  end

  // one register for all state; reset brings every field to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flip-flops
  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;
  assign irq = q.irq;
endmodule : rc_receiver

// File: logic/rc_tick.sv
// receive counter clock enable, one aclk pulse per prescaler wrap
`timescale 1ns/10ps
`include "rc_map.svh"
module rc_tick (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  output logic tick // one-cycle receive counter clock pulse
);
  import rc_pkg::*;
  tick_s q;
  tick_s n;

  // free-running divider so ticks stay evenly spaced across runs
  always_comb begin
    n = q;
    n.div = q.div + 6'h01;
    n.tick = (q.div == `RC_PRESC_LAST);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick;
endmodule : rc_tick

// File: test/rc_receiver_chk.sv
// bus and status assertions of the pulse receiver
`timescale 1ns/10ps
module rc_receiver_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [15:0] awaddr, // aw addr
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // b resp
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic [15:0] araddr, // ar addr
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp, // r resp
  input wire logic rvalid, // r valid
  input wire logic rready // r ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [15:0] ar_q;
  // keep the read address so its answer can be judged
  always_ff @(posedge aclk) begin
    if (arvalid && arready) ar_q <= araddr;
  end
  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd;
    arvalid && arready;
  endsequence
  property p_wr_ans;
    s_wr |-> ##[1:2] bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_wr_ro;
    s_wr ##0 (awaddr == 16'h3f48) |-> ##[1:2] (bvalid && bresp == 2'b00);
  endproperty
  a_wr_ro: assert property (p_wr_ro) else $error("read-only write refused");
  property p_wr_err;
    s_wr ##0 (awaddr == 16'h0010) |-> ##[1:2] (bvalid && bresp == 2'b10);
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("unmapped write accepted");
  property p_rd_err;
    s_rd ##0 (araddr == 16'h0010) |-> ##[1:2] (rvalid && rresp == 2'b10 && rdata == 0);
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read accepted");
  property p_r_once;
    rvalid && rready |=> !rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  property p_b_once;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  property p_stat;
    rvalid && ar_q == 16'h3f50 |-> rdata[31:8] == 0 && !rdata[3];
  endproperty
  a_stat: assert property (p_stat) else $error("status spare bits set");
endmodule : rc_receiver_chk

// File: test/rc_remote_model.sv
// far-side model: demodulated remote receiver output line
`timescale 1ns/10ps
module rc_remote_model (
  input wire logic aclk, // system clock
  output logic rc_in // remote line
);
  initial rc_in = 1'b0;
  // drive a level for n cycles; line idles low between frames
  task automatic hold(input logic v, input int n);
    @(posedge aclk);
    rc_in <= v;
    repeat (n) @(posedge aclk);
  endtask : hold
endmodule : rc_remote_model

// File: test/remote_signal_pulse_receiver_test.sv
// self-checking bench of the remote pulse receiver
`timescale 1ns/10ps
`include "rc_map.svh"
module remote_signal_pulse_receiver_test;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1, rc_in, awready, wready, bvalid, arready, rvalid, irq;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'h1;
  logic [1:0] bresp, rresp;
  int errors = 0, checked = 0, cyc = 0, seed = 32'hdc3a956d, b, e, th;
  int bq[$];
  rc_receiver #(.noise_scale_shift(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .rc_in(rc_in), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
  rc_remote_model i_rem (.aclk(aclk), .rc_in(rc_in));
  always #2 aclk = ~aclk;
  // byte address of register index i counted from the mode register
  function automatic logic [15:0] adr(input int i);
    return {`RC_IDX_MODE, 2'b00} + 16'(4 * i);
  endfunction : adr
  task automatic complete_run();
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // hang guard, well above the longest expected run
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] x);
    checked++;
    if (v !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, x, v);
    end
  endtask : chk
  // both ready lines stay high, so one edge ends each answer
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (!bvalid);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rc(input int i, input logic [31:0] x);
    logic [31:0] d;
    logic [1:0] r;
    rd(adr(i), d, r);
    chk($sformatf("reg%0d", i), d, x);
  endtask : rc
  // wait n receive counter ticks of 64 cycles
  task automatic ticks(input int n);
    repeat (n * 64) @(posedge aclk);
  endtask : ticks
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) rc(i, 0);
    // refused and ignored writes
    wr(16'h0010, 8'hff);
    rd(16'h0010, d, r);
    chk("rresp", {30'h0000_0000, r}, 32'h0000_0002);
    wr(adr(2), 8'hff);
    rc(2, 0);
    th = $random(seed) & 15;
    wr(adr(1), 8'(th << 4));
    rc(1, 32'(th << 4));
    wr(adr(6), 8'h03);
    // rising edge measurement, threshold one
    wr(adr(0), 8'h00);
    wr(adr(1), 8'h11);
    ticks(20);
    i_rem.hold(1'b1, 4);
    rd(adr(2), d, r);
    chk("capt", 32'(d >= 19 && d <= 21), 1);
    rc(4, 8'h01);
    rc(5, 8'h01);
    chk("irq", irq, 1);
    ticks(20);
    rc(4, 8'h03);
    wr(adr(5), 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 0);
    i_rem.hold(1'b0, 4);
    rc(5, 0);
    wr(adr(1), 8'h10);
    ticks(20);
    rc(4, 0);
    // overflow after 256 ticks, then masked and unmasked
    wr(adr(1), 8'h11);
    ticks(260);
    rc(4, 8'h04);
    rc(5, 8'h03);
    wr(adr(6), 8'h00);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 0);
    wr(adr(6), 8'h03);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 1);
    wr(adr(1), 8'h11);
    rc(4, 0);
    wr(adr(5), 8'h03);
    rc(5, 0);
    // polarity moves the measuring edge to the falling one
    wr(adr(0), 8'h01);
    i_rem.hold(1'b1, 4);
    rc(5, 0);
    i_rem.hold(1'b0, 4);
    rc(5, 8'h01);
    // both edges measure; then pulse width restarts timing at the falling edge
    wr(adr(5), 8'h01);
    wr(adr(0), 8'h04);
    i_rem.hold(1'b1, 4);
    rc(5, 8'h01);
    wr(adr(5), 8'h01);
    i_rem.hold(1'b0, 4);
    rc(5, 8'h01);
    wr(adr(0), 8'h10);
    i_rem.hold(1'b1, 2);
    ticks(20);
    i_rem.hold(1'b0, 2);
    i_rem.hold(1'b1, 2);
    rd(adr(2), d, r);
    chk("pw capt", 32'(d <= 1), 1);
    i_rem.hold(1'b0, 2);
    wr(adr(5), 8'h01);
    // receive end: long gap decides one, short gap zero
    wr(adr(0), 8'h06);
    wr(adr(1), 8'h11);
    e = 0;
    for (int i = 0; i < 8; i++) begin
      b = $random(seed) & 1;
      if (i == 7) rc(5, 0);
      ticks(b ? 24 : 8);
      i_rem.hold(1'b1, 2);
      i_rem.hold(1'b0, 2);
      bq.push_back(b);
    end
    // first bit received ends up in the top of the buffer
    foreach (bq[k]) e = (e << 1) | bq[k];
    rc(3, e);
    rc(4, 8'h80);
    rc(5, 8'h01);
    complete_run();
  end
endmodule : remote_signal_pulse_receiver_test
bind rc_receiver rc_receiver_chk i_chk (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
